// File: logic/atm_phy_status_diag_regs.sv
// Interrupt event and diagnostic control registers with their cell-side effects.
// Assumes receive and transmit engines on clk_sys report events as one-cycle pulses and
// that utility bus and RxEnb pins are asynchronous to clk_sys.
`timescale 1ns/1ps
module atm_phy_status_diag_regs (
  // Clock and reset.
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // Utility bus pins, muxed address and data.
  input  wire apsd_pkg::apsd_ub_ctl_t ub_ctl,
  input  wire logic [7:0]             ub_ad_in,
  output logic [7:0]                  ub_ad_out,
  output logic                        ub_ad_oe,
  // Settings owned by the master control and mask registers.
  input  wire logic                   par_check_en,
  input  wire logic                   int_enable,
  input  wire logic [5:0]             int_mask,
  input  wire logic                   byte_mode,
  // Receive event reports.
  input  wire logic                   good_signal,
  input  wire logic                   rx_hec_err,
  input  wire logic                   rx_byte,
  input  wire logic                   rx_soc,
  input  wire logic                   rx_sym_err,
  input  wire logic                   rx_fifo_drop,
  // Receive FIFO and UTOPIA receive side.
  input  wire logic                   rx_cell_avail,
  input  wire logic                   rx_byte_avail,
  input  wire logic                   rx_xfer,
  input  wire logic                   rx_xfer_soc,
  input  wire apsd_pkg::apsd_rx_pins_t rx_fifo_out,
  input  wire logic                   rx_enb_n,
  input  wire logic                   rx_flush_done,
  output logic                        rx_fifo_clear,
  output logic                        rx_clav,
  output apsd_pkg::apsd_rx_pins_t     rx_pins,
  output logic                        rx_pins_oe,
  // UTOPIA transmit side and line-bound byte stream.
  input  wire logic                   tx_room,
  input  wire logic                   tx_enb_byte,
  input  wire logic [7:0]             tx_data,
  input  wire logic                   tx_prty,
  input  wire logic                   tx_line_valid_in,
  input  wire logic [5:0]             tx_line_idx,
  input  wire logic [7:0]             tx_line_in,
  output logic                        tx_clav,
  output logic                        tx_line_valid,
  output logic [7:0]                  tx_line,
  // Loopback selection and interrupt pin.
  output apsd_pkg::apsd_loop_t        loop_sel,
  output logic                        int_n
);
  import apsd_pkg::*;

  // Register address match, shared by the read mux and the write decode.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    return a == target;
  endfunction

  // Two-flop synchronisers for the utility bus and RxEnb pins; only stage two is read.
  logic [12:0] sync1, sync2;
  logic [12:0] next_sync1;
  always_comb begin
    next_sync1 = {ub_ctl, ub_ad_in, rx_enb_n};
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1 <= SYNC_IDLE;
      sync2 <= SYNC_IDLE;
    end else begin
      sync1 <= next_sync1;
      sync2 <= sync1;
    end
  end
  logic       s_ale, s_cs_n, s_rd_n, s_wr_n, s_enb_n;
  logic [7:0] s_ad;
  assign {s_ale, s_cs_n, s_rd_n, s_wr_n, s_ad, s_enb_n} = sync2;

  // Bus handshake state: latched address, strobe history, read snapshot.
  logic [7:0] addr, next_addr;
  logic       rd_q, next_rd_q, wr_q, next_wr_q;
  logic [7:0] snap, next_snap;
  logic       next_ad_oe;
  logic [7:0] next_ad_out;
  logic       rd_start, rd_end, wr_end;
  logic [7:0] event_reg;
  logic [7:0] diag, next_diag;
  always_comb begin
    rd_start    = !s_rd_n && rd_q && !s_cs_n;
    rd_end      = s_rd_n && !rd_q;
    wr_end      = s_wr_n && !wr_q && !s_cs_n;
    next_addr   = s_ale ? s_ad : addr;
    next_rd_q   = s_rd_n;
    next_wr_q   = s_wr_n;
    next_snap   = snap;
    next_ad_out = ub_ad_out;
    next_ad_oe  = !s_rd_n && !s_cs_n;
    // Data is frozen at the start of the read so the pins stay stable for the strobe.
    if (rd_start) begin
      if (hit(addr, ADDR_EVENT)) begin
        next_ad_out = event_reg;
      end else if (hit(addr, ADDR_DIAG)) begin
        next_ad_out = diag;
      end else begin
        next_ad_out = 8'h00;
      end
      next_snap = hit(addr, ADDR_EVENT) ? event_reg : 8'h00;
    end
    // The snapshot is used once, so a later stray strobe cannot clear flags again.
    if (rd_end) begin
      next_snap = 8'h00;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      addr      <= 8'h00;
      rd_q      <= 1'b1;
      wr_q      <= 1'b1;
      snap      <= 8'h00;
      ub_ad_out <= 8'h00;
      ub_ad_oe  <= 1'b0;
    end else begin
      addr      <= next_addr;
      rd_q      <= next_rd_q;
      wr_q      <= next_wr_q;
      snap      <= next_snap;
      ub_ad_out <= next_ad_out;
      ub_ad_oe  <= next_ad_oe;
    end
  end

  // Sticky event flags; only flags seen at read start are cleared at read end.
  logic [EV_NUM-1:0] flags, next_flags, ev_set;
  logic              good_q, next_good_q;
  logic [5:0]        gap, next_gap;
  logic              seen_soc, next_seen_soc;
  logic              next_int_n;
  always_comb begin
    ev_set         = '0;
    ev_set[EV_HEC] = rx_hec_err;                                  // [RQ2]
    ev_set[EV_SHORT] = rx_soc && seen_soc && (gap < CELL_BYTES);  // [RQ3]
    ev_set[EV_PAR] = par_check_en && tx_enb_byte
                     && !(^{tx_data, tx_prty});                   // [RQ4] [RQ19]
    ev_set[EV_SIG] = good_signal != good_q;                       // [RQ5]
    ev_set[EV_SYM] = rx_sym_err;                                  // [RQ6]
    ev_set[EV_OVF] = rx_fifo_drop;                                // [RQ7]
    next_good_q    = good_signal;
    next_seen_soc  = seen_soc || rx_soc;
    next_gap       = gap;
    // The start byte itself counts as byte one of the new cell.
    if (rx_soc) begin
      next_gap = 6'h01;
    end else if (rx_byte && gap != IDX_SAT) begin
      next_gap = gap + 6'h01;
    end
    // A set in the clearing cycle wins over the clear.
    next_flags = flags;
    if (rd_end) begin
      next_flags = flags & ~snap[EV_NUM-1:0];                     // [RQ18]
    end
    next_flags = next_flags | ev_set;                             // [RQ21]
    next_int_n = !(int_enable && |(next_flags & ~int_mask));      // [RQ20]
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flags    <= '0;
      good_q   <= good_signal; // Seeded from the pin so no false change follows reset.
      gap      <= 6'h00;
      seen_soc <= 1'b0;
      int_n    <= 1'b1;
    end else begin
      flags    <= next_flags;
      good_q   <= next_good_q;
      gap      <= next_gap;
      seen_soc <= next_seen_soc;
      int_n    <= next_int_n;
    end
  end
  // Bit 7 reserved and zero; the live bit is not sticky.
  assign event_reg = {1'b0, good_signal, flags};                  // [RQ1] [RQ22]

  // Diagnostic register; the event register has no write path at all.
  always_comb begin
    next_diag = diag;
    if (wr_end && hit(addr, ADDR_DIAG)) begin
      next_diag = s_ad;
    end
    // Completion of a flush clears the request bit by hardware.
    if (rx_flush_done) begin
      next_diag[DG_FLUSH] = 1'b0;                                 // [RQ13]
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      diag <= DIAG_RESET;
    end else begin
      diag <= next_diag;
    end
  end

  // Cell-side controls driven from the diagnostic bits.
  logic                in_cell, next_in_cell;
  logic [5:0]          rx_idx, next_rx_idx;
  logic                next_rx_clav, next_tx_clav, next_oe, next_tx_vld;
  logic [7:0]          next_tx_line;
  apsd_rx_pins_t       next_pins;
  apsd_loop_t          next_loop;
  always_comb begin
    next_rx_idx  = rx_xfer_soc ? 6'h00 : rx_idx + 6'h01;
    next_in_cell = in_cell;
    next_rx_clav = rx_clav;
    if (!rx_xfer) begin
      next_rx_idx = rx_idx;
    end
    if (rx_xfer && rx_xfer_soc) begin
      next_in_cell = 1'b1;
    end
    if (byte_mode) begin
      next_rx_clav = rx_byte_avail;
    end else if (rx_xfer && next_rx_idx == IDX_LAST) begin
      next_in_cell = 1'b0;
      next_rx_clav = rx_cell_avail;                               // [RQ9]
    end else if (rx_xfer && diag[DG_EARLY] && next_rx_idx == IDX_PAY44) begin
      next_rx_clav = rx_cell_avail;                               // [RQ10]
    end else if (!in_cell) begin
      next_rx_clav = rx_cell_avail;
    end
    // Tri-state only in multi-PHY mode while the layer device is not enabling us.
    next_oe      = !diag[DG_MULTI] || !s_enb_n;                   // [RQ11] [RQ12]
    next_pins    = rx_fifo_out;
    next_tx_clav = tx_room && !diag[DG_TXCLAV_OFF];               // [RQ8]
    next_tx_vld  = tx_line_valid_in;
    next_tx_line = tx_line_in;
    if (tx_line_valid_in && diag[DG_HEC_ERR] && tx_line_idx == IDX_HEC) begin
      next_tx_line[0] = !tx_line_in[0];                           // [RQ15]
    end
    if (tx_line_valid_in && diag[DG_PAY_ERR] && tx_line_idx == IDX_LAST) begin
      next_tx_line[0] = !tx_line_in[0];                           // [RQ14]
    end
    // Code 10 works only at 1x multiplier; software must pick 01 otherwise.
    next_loop = apsd_loop_t'(diag[DG_LOOP_HI:DG_LOOP_LO]);        // [RQ16] [RQ17]
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      in_cell       <= 1'b0;
      rx_idx        <= 6'h00;
      rx_clav       <= 1'b0;
      rx_pins_oe    <= 1'b0;
      rx_pins       <= '0;
      tx_clav       <= 1'b0;
      tx_line_valid <= 1'b0;
      tx_line       <= 8'h00;
      loop_sel      <= APSD_LOOP_NORMAL;
      rx_fifo_clear <= 1'b0;
    end else begin
      in_cell       <= next_in_cell;
      rx_idx        <= next_rx_idx;
      rx_clav       <= next_rx_clav;
      rx_pins_oe    <= next_oe;
      rx_pins       <= next_pins;
      tx_clav       <= next_tx_clav;
      tx_line_valid <= next_tx_vld;
      tx_line       <= next_tx_line;
      loop_sel      <= next_loop;
      rx_fifo_clear <= next_diag[DG_FLUSH];                       // [RQ13]
    end
  end

  // Checks on the logic above.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_HEC_STICKY: assert property (rx_hec_err |=> flags[EV_HEC]) // [RQ2]
    else $error("HEC flag not set");
  AST_SHORT: assert property (rx_soc && seen_soc && gap < CELL_BYTES // [RQ3]
    |=> flags[EV_SHORT])
    else $error("short cell not flagged");
  AST_PAR_OFF: assert property (!par_check_en && !flags[EV_PAR] && !rd_end // [RQ19]
    |=> !flags[EV_PAR])
    else $error("parity flagged while disabled");
  AST_PAR_ON: assert property (par_check_en && tx_enb_byte && !(^{tx_data, tx_prty}) // [RQ4]
    |=> flags[EV_PAR])
    else $error("parity error missed");
  AST_SIG: assert property ($changed(good_signal) |-> ##1 flags[EV_SIG]) // [RQ5]
    else $error("signal change not flagged");
  AST_CLEAR_KEEP: assert property (rd_end && rx_sym_err |=> flags[EV_SYM]) // [RQ21]
    else $error("event lost in clearing read");
  AST_CLEAR: assert property (rd_end && snap[EV_OVF] && !rx_fifo_drop // [RQ18]
    |=> !flags[EV_OVF])
    else $error("sticky flag not cleared by read");
  AST_TXCLAV: assert property (diag[DG_TXCLAV_OFF] |=> !tx_clav) // [RQ8]
    else $error("TxClav high while forced off");
  AST_TRI: assert property (!diag[DG_MULTI] ##1 !diag[DG_MULTI] |-> rx_pins_oe) // [RQ11]
    else $error("pins floated in single-PHY mode");
  AST_INT: assert property (!int_enable ##1 !int_enable |-> int_n) // [RQ20]
    else $error("interrupt low while disabled");
  AST_BIT7: assert property ( // [RQ1] [RQ22]
    event_reg[7] == 1'b0 && event_reg[EV_GOOD] == good_signal)
    else $error("event register bits 7/6 wrong");
  AST_HEC_INJ: assert property ( // [RQ15]
    tx_line_valid_in && diag[DG_HEC_ERR] && tx_line_idx == IDX_HEC
    |=> tx_line[0] != $past(tx_line_in[0]))
    else $error("HEC byte not corrupted");
  AST_PAY_INJ: assert property ( // [RQ14]
    tx_line_valid_in && diag[DG_PAY_ERR] && tx_line_idx == IDX_LAST
    |=> tx_line[0] != $past(tx_line_in[0]))
    else $error("last payload byte not corrupted");
  // Remaining event flags and the interrupt pin.
  AST_SYM: assert property (rx_sym_err |=> flags[EV_SYM]) // [RQ6]
    else $error("symbol error not flagged");
  AST_OVF: assert property (rx_fifo_drop |=> flags[EV_OVF]) // [RQ7]
    else $error("FIFO overflow not flagged");
  AST_INT_ON: assert property (int_enable && |(next_flags & ~int_mask) |=> !int_n) // [RQ20]
    else $error("interrupt not raised");
  // Cell-side checks; the hold check shows standard mode keeps RxClav past payload byte 44.
  AST_CLAV_STD: assert property ( // [RQ9]
    !byte_mode && rx_xfer && next_rx_idx == IDX_LAST
    |=> rx_clav == $past(rx_cell_avail))
    else $error("RxClav not updated after the last byte");
  AST_CLAV_HOLD: assert property ( // [RQ9]
    !byte_mode && rx_xfer && !diag[DG_EARLY] && next_rx_idx == IDX_PAY44 && rx_clav && in_cell
    |=> rx_clav)
    else $error("RxClav dropped early in standard mode");
  AST_CLAV_EARLY: assert property ( // [RQ10]
    !byte_mode && rx_xfer && diag[DG_EARLY] && next_rx_idx == IDX_PAY44 && !rx_cell_avail
    |=> !rx_clav)
    else $error("RxClav not dropped early");
  AST_FLOAT: assert property (diag[DG_MULTI] && s_enb_n |=> !rx_pins_oe) // [RQ12]
    else $error("pins driven while not enabled in multi-PHY mode");
  AST_FLUSH: assert property (rx_flush_done |=> !rx_fifo_clear && !diag[DG_FLUSH]) // [RQ13]
    else $error("flush bit not cleared on completion");
  AST_LOOP: assert property ( // [RQ16]
    1'b1 |=> loop_sel == apsd_loop_t'($past(diag[DG_LOOP_HI:DG_LOOP_LO])))
    else $error("loopback select does not follow the register");

  // Main scenarios that the bench is expected to reach.
  COV_SHORT: cover property (flags[EV_SHORT] ##1 rd_end);
  COV_FLUSH: cover property (diag[DG_FLUSH] ##[1:20] !diag[DG_FLUSH]);
  COV_EARLY: cover property (diag[DG_EARLY] && rx_clav ##1 !rx_clav && in_cell);
  COV_DIAG_WRITE: cover property (wr_end && hit(addr, ADDR_DIAG));
  COV_INT: cover property (int_n ##1 !int_n);
endmodule : atm_phy_status_diag_regs

// File: logic/apsd_pkg.sv
// Constants, field positions and carrier types for the status/diagnostic register pair.
// Assumes one 25 MHz clock domain and the utility bus pins as the only register access.
// Overview of operation
// RQ1 - Event register bit 6 is read-only and shows live good-signal state.
// RQ2 - Bit 5 sets on any received header check failure, held until read.
// RQ3 - Bit 4 sets when start-of-cell bytes arrive fewer than 53 bytes apart.
// RQ4 - With parity check on, bit 3 sets on any odd parity mismatch.
// RQ5 - Bit 2 sets on every good-signal change in either direction.
// RQ6 - Bit 1 sets when an undefined 5-bit line symbol is decoded.
// RQ7 - Bit 0 sets when the receive FIFO is full and drops data.
// RQ8 - Diagnostic bit 7 holds TxClav low; resets to 0.
// RQ9 - Bit 6 clear: RxClav drops after final byte of last complete cell.
// RQ10 - Bit 6 set: RxClav drops after payload byte 44 if no cell follows.
// RQ11 - Bit 5 clear: receive data, parity and start pins always driven.
// RQ12 - Bit 5 set, the reset value: those pins float while RxEnb high.
// RQ13 - Writing receive FIFO clear empties it; bit self-clears when done.
// RQ14 - Bit 3 set inverts bit 0 of each cell's last payload byte.
// RQ15 - Bit 2 set inverts bit 0 of the fifth header byte.
// RQ16 - Loopback field: 00 normal, 01 PHY with recovery, 10 PHY, 11 line.
// RQ17 - Software uses code 10 only at 1x multiplier, else code 01.
// RQ18 - Sticky flags clear when their register is read; not writable.
// RQ19 - Transmit parity checking runs only while the master enable is set.
// RQ20 - Interrupts enabled and unmasked flag set drives interrupt low, else high.
// RQ21 - An event in the same cycle as the clearing read stays flagged.
// RQ22 - Writes to the event register do nothing; bit 7 reads 0.
package apsd_pkg;
  localparam logic [7:0] ADDR_EVENT = 8'h01;
  localparam logic [7:0] ADDR_DIAG  = 8'h02;
  localparam logic [7:0] DIAG_RESET = 8'h20;
  // Synchroniser idle pattern {ale, cs_n, rd_n, wr_n, ad, RxEnb}: strobes and RxEnb high.
  localparam logic [12:0] SYNC_IDLE = 13'h0e01;
  // Event register field positions.
  localparam int EV_GOOD  = 6;
  localparam int EV_HEC   = 5;
  localparam int EV_SHORT = 4;
  localparam int EV_PAR   = 3;
  localparam int EV_SIG   = 2;
  localparam int EV_SYM   = 1;
  localparam int EV_OVF   = 0;
  localparam int EV_NUM   = 6;
  // Diagnostic register field positions.
  localparam int DG_TXCLAV_OFF = 7;
  localparam int DG_EARLY      = 6;
  localparam int DG_MULTI      = 5;
  localparam int DG_FLUSH      = 4;
  localparam int DG_PAY_ERR    = 3;
  localparam int DG_HEC_ERR    = 2;
  localparam int DG_LOOP_HI    = 1;
  localparam int DG_LOOP_LO    = 0;
  // Cell geometry, byte indices count from 0 at the start of cell.
  localparam logic [5:0] CELL_BYTES  = 6'd53;
  localparam logic [5:0] IDX_HEC     = 6'h04;
  localparam logic [5:0] IDX_PAY44   = 6'h30;
  localparam logic [5:0] IDX_LAST    = 6'h34;
  localparam logic [5:0] IDX_SAT     = 6'h3f;
  typedef enum logic [1:0] {
    APSD_LOOP_NORMAL,
    APSD_LOOP_PHY_REC,
    APSD_LOOP_PHY,
    APSD_LOOP_LINE
  } apsd_loop_t;
  // Receive cell-side pin group.
  typedef struct packed {
    logic [7:0] data;
    logic       prty;
    logic       soc;
  } apsd_rx_pins_t;
  // Utility bus control pins, all active low except address latch.
  typedef struct packed {
    logic ale;
    logic cs_n;
    logic rd_n;
    logic wr_n;
  } apsd_ub_ctl_t;
endpackage : apsd_pkg

// File: sim/apsd_atm_layer.sv
// ATM layer device model: transmit byte source and RxEnb driver.
// Assumes the bench calls send_byte and drives rx_want between clock edges.
`timescale 1ns/1ps
module apsd_atm_layer (
  // Clock.
  input  wire logic  clk_sys,
  // PHY transmit availability and bench receive request.
  input  wire logic  tx_clav,
  input  wire logic  rx_want,
  // Transmit strobe, data, parity and receive enable.
  output logic       tx_enb_byte,
  output logic [7:0] tx_data,
  output logic       tx_prty,
  output logic       rx_enb_n
);
  initial begin
    tx_enb_byte = 1'b0;
    tx_data     = 8'h00;
    tx_prty     = 1'b1;
    rx_enb_n    = 1'b1;
  end
  // The enable pin changes only off the sampling edge.
  always @(negedge clk_sys) begin
    rx_enb_n <= !rx_want;
  end
  // A byte is offered only while TxClav is high; bad parity only on request.
  task automatic send_byte(input logic bad);
    @(negedge clk_sys);
    if (tx_clav === 1'b1) begin
      tx_data     = 8'($urandom);
      tx_prty     = (~^tx_data) ^ bad;
      tx_enb_byte = 1'b1;
    end
    @(negedge clk_sys);
    tx_enb_byte = 1'b0;
    tx_data     = ~tx_data; // Released data must not keep its last value.
  endtask
endmodule // apsd_atm_layer

// File: sim/apsd_tb.sv
// Self-checking bench for the event and diagnostic register pair.
// Assumes the design in logic/ and the ATM layer model in sim/.
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin total_checks++; if ((sn) !== (ex)) begin miscompares++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, sn); end end
module testbench;
  import apsd_pkg::*;
  logic          clk_sys = 1'b0, rst = 1'b1, ub_ad_oe, oe_q = 1'b0;
  apsd_ub_ctl_t  ub_ctl = 4'b0111;
  logic [7:0]    ad_drv = 8'h00, ub_ad_in, ub_ad_out, tx_data, tx_line, exp_v, dv;
  logic [7:0]    tx_line_in = 8'h00, exp_l;
  logic          byte_mode = 1'b0, rx_byte_avail = 1'b0;
  logic          par_check_en = 1'b0, int_enable = 1'b0, good_signal = 1'b1, rx_want = 1'b0;
  logic          rx_hec_err = 1'b0, rx_byte = 1'b0, rx_soc = 1'b0, rx_sym_err = 1'b0;
  logic          rx_fifo_drop = 1'b0, rx_cell_avail = 1'b0, rx_xfer = 1'b0, rx_xfer_soc = 1'b0;
  logic          rx_flush_done = 1'b0, tx_line_valid_in = 1'b0, rx_enb_n, rx_fifo_clear;
  logic          rx_clav, rx_pins_oe, tx_enb_byte, tx_prty, tx_clav, tx_line_valid, int_n;
  logic [5:0]    int_mask = 6'h00, tx_line_idx = 6'h00, m;
  logic [5:0]    idx_tab [4] = '{6'h00, 6'h04, 6'h30, 6'h34};
  apsd_rx_pins_t rx_fifo_out = '0, rx_pins;
  apsd_loop_t    loop_sel;
  logic [7:0]    exp_q [$];
  int            miscompares = 0, total_checks = 0, cycles = 0;
  always #20 clk_sys = ~clk_sys;
  // The muxed bus carries whichever party has its driver enabled.
  assign ub_ad_in = ub_ad_oe ? ub_ad_out : ad_drv;
  atm_phy_status_diag_regs DUT (.clk_sys(clk_sys), .rst(rst), .ub_ctl(ub_ctl),
    .ub_ad_in(ub_ad_in), .ub_ad_out(ub_ad_out), .ub_ad_oe(ub_ad_oe),
    .par_check_en(par_check_en), .int_enable(int_enable), .int_mask(int_mask),
    .byte_mode(byte_mode), .good_signal(good_signal), .rx_hec_err(rx_hec_err), .rx_byte(rx_byte),
    .rx_soc(rx_soc), .rx_sym_err(rx_sym_err), .rx_fifo_drop(rx_fifo_drop),
    .rx_cell_avail(rx_cell_avail), .rx_byte_avail(rx_byte_avail), .rx_xfer(rx_xfer),
    .rx_xfer_soc(rx_xfer_soc), .rx_fifo_out(rx_fifo_out), .rx_enb_n(rx_enb_n),
    .rx_flush_done(rx_flush_done), .rx_fifo_clear(rx_fifo_clear), .rx_clav(rx_clav),
    .rx_pins(rx_pins), .rx_pins_oe(rx_pins_oe), .tx_room(1'b1), .tx_enb_byte(tx_enb_byte),
    .tx_data(tx_data), .tx_prty(tx_prty), .tx_line_valid_in(tx_line_valid_in),
    .tx_line_idx(tx_line_idx), .tx_line_in(tx_line_in), .tx_clav(tx_clav),
    .tx_line_valid(tx_line_valid), .tx_line(tx_line), .loop_sel(loop_sel), .int_n(int_n));
  apsd_atm_layer u_atm (.clk_sys(clk_sys), .tx_clav(tx_clav), .rx_want(rx_want),
    .tx_enb_byte(tx_enb_byte), .tx_data(tx_data), .tx_prty(tx_prty), .rx_enb_n(rx_enb_n));
  // Read data is compared with the oldest note when the driver turns on.
  always @(negedge clk_sys) begin
    oe_q <= ub_ad_oe;
    if (ub_ad_oe === 1'b1 && oe_q !== 1'b1) begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
      `CHK("ub_ad_out", exp_v, ub_ad_out)
    end
  end
  // A hang ends the run as a failure.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  // Address phase, then a strobe held long enough for the two-stage synchroniser.
  task automatic ub_cycle(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    ub_ctl.ale = 1'b1;
    ad_drv = a;
    repeat (3) @(negedge clk_sys);
    ub_ctl.ale = 1'b0;
    ad_drv = wr ? d : ~a;
    ub_ctl.cs_n = 1'b0;
    if (wr) ub_ctl.wr_n = 1'b0;
    else ub_ctl.rd_n = 1'b0;
    repeat (6) @(negedge clk_sys);
    ub_ctl.wr_n = 1'b1;
    ub_ctl.rd_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    ub_ctl.cs_n = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    ub_cycle(1'b0, a, 8'h00);
  endtask
  task automatic soc_then(input int n);
    @(negedge clk_sys);
    rx_soc = 1'b1;
    @(negedge clk_sys);
    rx_soc = 1'b0;
    rx_byte = (n > 0);
    repeat (n) @(negedge clk_sys);
    rx_byte = 1'b0;
  endtask
  task automatic conclude();
    if (exp_q.size() != 0) miscompares++; // A read that never answered is a mismatch.
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    m = 6'($urandom(32'h5ecf493d));
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    rd(ADDR_DIAG, 8'h20);
    `CHK("tx_clav", 1'b1, tx_clav)
    wr_ev: ub_cycle(1'b1, ADDR_EVENT, 8'hff);
    rd(8'h05, 8'h00);
    rd(ADDR_EVENT, 8'h40);
    good_signal = 1'b0;
    rd(ADDR_EVENT, 8'h04);
    good_signal = 1'b1;
    rd(ADDR_EVENT, 8'h44);
    rd(ADDR_EVENT, 8'h40);
    soc_then(52);
    soc_then(51);
    soc_then(0);
    rd(ADDR_EVENT, 8'h50);
    $display("test reset_and_short_cell done");
    // Random event sets; bad parity is always sent but counts only with checking on.
    for (int i = 0; i < 4; i++) begin
      m = 6'($urandom);
      int_mask = 6'($urandom);
      int_enable = 1'($urandom);
      par_check_en = m[3];
      @(negedge clk_sys);
      {rx_hec_err, rx_sym_err, rx_fifo_drop, good_signal} = {m[5], m[1], m[0], !m[2]};
      @(negedge clk_sys);
      {rx_hec_err, rx_sym_err, rx_fifo_drop, good_signal} = 4'h1;
      if (m[4]) soc_then(3);
      if (m[4]) soc_then(0);
      u_atm.send_byte(1'b1);
      repeat (2) @(negedge clk_sys);
      `CHK("int_n", !(int_enable && |(m & ~int_mask)), int_n)
      rd(ADDR_EVENT, {2'b01, m});
      rd(ADDR_EVENT, 8'h40);
    end
    $display("test events done");
    ub_cycle(1'b1, ADDR_DIAG, 8'ha0);
    `CHK("tx_clav", 1'b0, tx_clav)
    // Code 10 is used only because the bench runs at a 1x multiplier.
    for (int c = 0; c < 4; c++) begin
      dv = 8'h20 | 8'(c) | 8'(c << 2);
      ub_cycle(1'b1, ADDR_DIAG, dv);
      rd(ADDR_DIAG, dv);
      `CHK("loop_sel", apsd_loop_t'(c), loop_sel)
      for (int k = 0; k < 4; k++) begin
        tx_line_valid_in = 1'b1;
        tx_line_idx = idx_tab[k];
        tx_line_in = 8'($urandom);
        @(negedge clk_sys);
        exp_l = tx_line_in ^ 8'((k == 1 && c[0]) || (k == 3 && c[1]));
        `CHK("tx_line", exp_l, tx_line)
        `CHK("tx_line_valid", 1'b1, tx_line_valid)
      end
      tx_line_valid_in = 1'b0;
    end
    $display("test loopback_and_corrupt done");
    rx_want = 1'b1;
    rx_fifo_out = 10'($urandom);
    repeat (6) @(negedge clk_sys);
    `CHK("rx_pins_oe", 1'b1, rx_pins_oe)
    `CHK("rx_pins", rx_fifo_out, rx_pins)
    rx_want = 1'b0;
    repeat (6) @(negedge clk_sys);
    `CHK("rx_pins_oe", 1'b0, rx_pins_oe)
    ub_cycle(1'b1, ADDR_DIAG, 8'h10);
    `CHK("rx_pins_oe", 1'b1, rx_pins_oe)
    `CHK("rx_fifo_clear", 1'b1, rx_fifo_clear)
    rx_flush_done = 1'b1;
    @(negedge clk_sys);
    rx_flush_done = 1'b0;
    @(negedge clk_sys);
    `CHK("rx_fifo_clear", 1'b0, rx_fifo_clear)
    rd(ADDR_DIAG, 8'h00);
    $display("test tristate_and_flush done");
    for (int e = 0; e < 2; e++) begin
      ub_cycle(1'b1, ADDR_DIAG, 8'(e << 6));
      rx_cell_avail = 1'b1;
      repeat (2) @(negedge clk_sys);
      for (int k = 0; k < 53; k++) begin
        {rx_xfer, rx_xfer_soc} = {1'b1, k == 0};
        if (k == 1) rx_cell_avail = 1'b0;
        @(negedge clk_sys);
        `CHK("rx_clav", 1'(k < (e ? 48 : 52)), rx_clav)
      end
      {rx_xfer, rx_xfer_soc} = 2'b00;
    end
    // Byte mode follows the byte flag, not the cell flag.
    byte_mode = 1'b1;
    rx_byte_avail = 1'b1;
    @(negedge clk_sys);
    `CHK("rx_clav", 1'b1, rx_clav)
    rx_byte_avail = 1'b0;
    @(negedge clk_sys);
    `CHK("rx_clav", 1'b0, rx_clav)
    byte_mode = 1'b0;
    $display("test rx_clav done");
    conclude();
  end
endmodule // testbench
